// File: verilog/rdm_ctrl.sv
// Control logic of a dual-channel re-driver with a 2:1 orientation mux.
// Assumes all inputs synchronous to pclk and analog detectors outside.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps

module rdm_ctrl #(
  parameter int DET_PERIOD = 1000
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             orientation_select,
  input  wire logic [1:0]       proc_cfg_a,
  input  wire logic [1:0]       proc_cfg_b,
  input  wire logic [1:0]       conn_cfg_a,
  input  wire logic [1:0]       conn_cfg_b,
  input  wire logic             term_det_done,
  input  wire logic             term_det_both,
  input  wire logic             lfps_det_proc,
  input  wire logic             lfps_det_conn,
  input  wire logic             traffic_det,
  output rdm_pkg::rdm_mux_t     mux_out,
  output rdm_pkg::rdm_set_t     proc_drv,
  output rdm_pkg::rdm_set_t     conn_drv,
  output logic                  rxdet_req,
  output logic                  rx_term_en,
  output logic                  out_idle
);

  // Power states of the link manager.
  typedef enum logic [1:0] {ST_DISC, ST_U23, ST_U0} rdm_state_t;

  // Reload value that spaces detection requests DET_PERIOD cycles apart.
  localparam logic [15:0] DET_RELOAD = 16'(DET_PERIOD - 1);

  rdm_state_t        state_reg;      // Current power state.
  rdm_state_t        state_next;     // Next power state.
  logic [15:0]       det_cnt_reg;    // Countdown to the next detection request.
  logic [15:0]       det_cnt_next;   // Next detection countdown.
  logic              rxdet_next;     // Next detection request pulse.
  logic [3:0]        idle_cnt_reg;   // Cycles the idle target has differed.
  logic [3:0]        idle_cnt_next;  // Next idle delay count.
  logic              idle_next;      // Next electrical idle output.
  logic              idle_target;    // Idle level the output is heading for.
  logic              lfps_any;       // LFPS seen on either input.
  logic [1:0]        ctrl_reg;       // Detection enable and LFPS automatic control.
  logic [1:0]        ctrl_next;      // Next control value.
  logic [31:0]       prdata_next;    // Next read data.
  logic              pready_next;    // Next ready.
  logic              pslverr_next;   // Next error.
  logic              mapped;         // Address hits a register.
  rdm_pkg::rdm_set_t proc_tbl_set;   // Processor-side table entry.
  rdm_pkg::rdm_set_t conn_tbl_set;   // Connector-side table entry.
  rdm_pkg::rdm_set_t proc_drv_next;  // Next processor-side setting.
  rdm_pkg::rdm_set_t conn_drv_next;  // Next connector-side setting.
  rdm_pkg::rdm_mux_t mux_next;       // Next routing.
  logic [1:0]        ps_code;        // Power state as a status code.

  // Maps a pin level code to 0, 1 or 2; the unused code counts as float.
  function automatic logic [3:0] lvl(input logic [1:0] code);
    logic [3:0] r;
    r = {2'h0, code};
    // The spare code is read as a floating pin, the middle setting.
    if (code == 2'h3) begin
      r = {2'h0, rdm_pkg::LVL_FLOAT};
    end
    return r;
  endfunction

  // Forms the table index from the two level codes of a pin pair.
  function automatic logic [3:0] tbl_idx(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] r;
    r = 4'((lvl(a) * 4'h3) + lvl(b));
    return r;
  endfunction

  assign lfps_any = lfps_det_proc | lfps_det_conn;

  // Power state machine and the periodic far-end termination poll.
  always_comb begin
    // Hold the state and the poll counter unless a branch below moves them.
    state_next   = state_reg;
    det_cnt_next = det_cnt_reg;
    rxdet_next   = 1'b0;
    case (state_reg)
      ST_DISC: begin
        // Only a hit on both transmit outputs counts as a connection.
        if (term_det_done && term_det_both) begin
          state_next = ST_U0; // RULE_05
        end
      end
      ST_U0: begin
        // Traffic or signalling keeps the link active.
        if (!traffic_det && !lfps_any) begin
          state_next = ST_U23; // RULE_06
        end
      end
      ST_U23: begin
        // Signalling wakes the link; a lost partner drops to disconnect.
        if (traffic_det || lfps_any) begin
          state_next = ST_U0;
        end else if (term_det_done && !term_det_both) begin
          state_next = ST_DISC; // RULE_07
        end
      end
      default: begin
        // An unused code falls back to the lowest power state.
        state_next = ST_DISC; // RULE_04
      end
    endcase
    // Detection repeats outside U0 while software leaves it enabled.
    if (ctrl_reg[rdm_pkg::CTRL_DET_EN] && state_reg != ST_U0) begin
      if (det_cnt_reg == 16'h0000) begin
        rxdet_next   = 1'b1; // RULE_03
        det_cnt_next = DET_RELOAD;
      end else begin
        det_cnt_next = det_cnt_reg - 16'h0001;
      end
    end else begin
      det_cnt_next = DET_RELOAD;
    end
  end

  // Electrical idle follows signal presence, and is forced in disconnect, after the entry or exit delay.
  always_comb begin
    idle_target   = !(traffic_det || lfps_any) || state_reg == ST_DISC;
    idle_next     = out_idle;
    idle_cnt_next = 4'h0;
    // The delay count only runs while a change of level is pending.
    if (idle_target != out_idle) begin
      // A pending change waits out its own delay; the count restarts on a bounce.
      if (idle_cnt_reg + 4'h1 >= (idle_target ? rdm_pkg::IDLE_ENTRY : rdm_pkg::IDLE_EXIT)) begin
        idle_next = idle_target; // RULE_12 RULE_13
      end else begin
        idle_cnt_next = idle_cnt_reg + 4'h1;
      end
    end
  end

  // Settings from the straps, routing from orientation, LFPS override.
  always_comb begin
    // Both tables are indexed by the two level codes of their pin pair.
    proc_tbl_set  = rdm_pkg::PROC_TBL[tbl_idx(proc_cfg_a, proc_cfg_b)]; // RULE_09 RULE_10 RULE_14
    conn_tbl_set  = rdm_pkg::CONN_TBL[tbl_idx(conn_cfg_a, conn_cfg_b)]; // RULE_11
    proc_drv_next = proc_tbl_set;
    conn_drv_next = conn_tbl_set;
    // The driver toward the processor re-drives what the connector receives.
    if (ctrl_reg[rdm_pkg::CTRL_LFPS_AUTO] && lfps_det_conn) begin
      proc_drv_next.de = rdm_pkg::DE_0DB; // RULE_08
    end
    if (ctrl_reg[rdm_pkg::CTRL_LFPS_AUTO] && lfps_det_proc) begin
      conn_drv_next.de = rdm_pkg::DE_0DB; // RULE_08
    end
    // The selected channel carries the pairs; the other is only weakly terminated.
    mux_next.ch1_active       = orientation_select; // RULE_01
    mux_next.ch2_active       = !orientation_select;
    mux_next.ch1_rx_weak_term = !orientation_select; // RULE_02
    mux_next.ch2_rx_weak_term = orientation_select;
  end

  // APB slave: one wait state, read data and error valid with ready.
  always_comb begin
    // Fixed status codes keep software independent of the enum encoding.
    case (state_reg)
      ST_U0:   ps_code = rdm_pkg::PS_U0;
      ST_U23:  ps_code = rdm_pkg::PS_U23;
      default: ps_code = rdm_pkg::PS_DISC;
    endcase
    // Only the three registers are mapped; any other address is refused.
    mapped       = paddr == rdm_pkg::ADDR_CTRL || paddr == rdm_pkg::ADDR_STATUS ||
                   paddr == rdm_pkg::ADDR_SETTINGS;
    pready_next  = psel && penable && !pready;
    pslverr_next = pready_next && !mapped;
    prdata_next  = 32'h0000_0000;
    ctrl_next    = ctrl_reg;
    // Read data is registered so that it stands in the same cycle as ready.
    if (pready_next && !pwrite) begin
      case (paddr)
        rdm_pkg::ADDR_CTRL:     prdata_next = {30'h0, ctrl_reg};
        rdm_pkg::ADDR_STATUS:   prdata_next = {27'h0, rx_term_en, out_idle, orientation_select, ps_code};
        rdm_pkg::ADDR_SETTINGS: prdata_next = {19'h0, conn_drv, 3'h0, proc_drv};
        default:                prdata_next = 32'h0000_0000;
      endcase
    end
    // A write takes effect on the edge that completes the access.
    if (psel && penable && pready && pwrite && paddr == rdm_pkg::ADDR_CTRL) begin
      ctrl_next = pwdata[1:0];
    end
  end

  // All state and every output register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset leaves the output idle and both control bits enabled.
      state_reg    <= ST_DISC;
      det_cnt_reg  <= 16'h0000;
      rxdet_req    <= 1'b0;
      rx_term_en   <= 1'b0;
      idle_cnt_reg <= 4'h0;
      out_idle     <= 1'b1;
      ctrl_reg     <= rdm_pkg::CTRL_RESET;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      proc_drv     <= '0;
      conn_drv     <= '0;
      mux_out      <= '0;
    end else begin
      // Every register loads its next value on each edge.
      state_reg    <= state_next;
      det_cnt_reg  <= det_cnt_next;
      rxdet_req    <= rxdet_next;
      rx_term_en   <= state_next != ST_DISC; // RULE_03
      idle_cnt_reg <= idle_cnt_next;
      out_idle     <= idle_next;
      ctrl_reg     <= ctrl_next;
      prdata       <= prdata_next;
      pready       <= pready_next;
      pslverr      <= pslverr_next;
      proc_drv     <= proc_drv_next;
      conn_drv     <= conn_drv_next;
      mux_out      <= mux_next;
    end
  end

  // Checks on the behaviour above.
  // Idle delays truncate to whole cycles, at least one; these bound the idle windows below.
  localparam int ENTRY_W = rdm_pkg::IDLE_ENTRY_CYC;
  localparam int EXIT_W  = rdm_pkg::IDLE_EXIT_CYC;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Routing and termination of the two connector channels.
  // The first edge after a reset release still shows the reset routing, so it is skipped.
  chk_mux_route: assert property ($past(presetn) |-> mux_out.ch1_active == $past(orientation_select) && // RULE_01
    mux_out.ch2_active != mux_out.ch1_active) else $error("routing does not follow orientation");
  chk_weak_term: assert property (mux_out.ch1_active |-> mux_out.ch2_rx_weak_term && // RULE_02
    !mux_out.ch1_rx_weak_term) else $error("unselected receive pair not weakly terminated");

  // Power states and the far-end detection poll.
  chk_term_en: assert property ((state_reg == ST_DISC && term_det_done && term_det_both) |=> // RULE_03
    rx_term_en && state_reg == ST_U0) else $error("termination not enabled after detection");
  chk_three_st: assert property (state_reg inside {ST_DISC, ST_U23, ST_U0}) // RULE_04
    else $error("illegal power state");
  chk_disc_hold: assert property ((state_reg == ST_DISC && !(term_det_done && term_det_both)) |=> // RULE_05
    state_reg == ST_DISC) else $error("left disconnect without both terminations");
  chk_u0_hold: assert property ((state_reg == ST_U0 && traffic_det) |=> state_reg == ST_U0) // RULE_06
    else $error("left U0 while traffic present");
  chk_u23_poll: assert property ((state_reg == ST_U23 && ctrl_reg[rdm_pkg::CTRL_DET_EN] && // RULE_07
    det_cnt_reg == 16'h0000) |=> rxdet_req) else $error("no detection request in U2/U3");
  // The reset release edge is skipped: the request register was still held in reset then.
  chk_disc_poll: assert property ((presetn && state_reg == ST_DISC && ctrl_reg[rdm_pkg::CTRL_DET_EN] && // RULE_05
    det_cnt_reg == 16'h0000) |=> rxdet_req) else $error("no detection request in disconnect");
  chk_u0_leave: assert property ((state_reg == ST_U0 && !traffic_det && !lfps_any) |=> // RULE_04
    state_reg == ST_U23) else $error("U0 kept without traffic");
  chk_u23_drop: assert property ((state_reg == ST_U23 && !traffic_det && !lfps_any && term_det_done && // RULE_07
    !term_det_both) |=> state_reg == ST_DISC) else $error("U2/U3 kept after lost termination");
  chk_no_poll_u0: assert property (state_reg == ST_U0 |=> !rxdet_req) // RULE_06
    else $error("detection request in U0");

  // Driver settings from the straps and the LFPS override.
  chk_lfps_de: assert property ((presetn && ctrl_reg[rdm_pkg::CTRL_LFPS_AUTO] && lfps_det_proc) |=> // RULE_08
    conn_drv.de == rdm_pkg::DE_0DB) else $error("de-emphasis kept during LFPS");
  chk_lfps_pde: assert property ((presetn && ctrl_reg[rdm_pkg::CTRL_LFPS_AUTO] && lfps_det_conn) |=> // RULE_08
    proc_drv.de == rdm_pkg::DE_0DB) else $error("processor de-emphasis kept during LFPS");
  chk_cfg_float: assert property ((proc_cfg_a == 2'h1 && proc_cfg_b == 2'h1 && !lfps_det_conn) |=> // RULE_09 RULE_10
    proc_drv == rdm_pkg::rdm_set_t'({rdm_pkg::DE_35DB, rdm_pkg::OS_11V, rdm_pkg::EQ_0DB}))
    else $error("processor float setting wrong");
  chk_cfg_conn: assert property ((conn_cfg_a == 2'h2 && conn_cfg_b == 2'h2 && !lfps_det_proc) |=> // RULE_11
    conn_drv == rdm_pkg::rdm_set_t'({rdm_pkg::DE_6DB, rdm_pkg::OS_11V, rdm_pkg::EQ_9DB}))
    else $error("connector high setting wrong");

  // Electrical idle timing and the single-cycle APB ready.
  chk_idle_disc: assert property (state_reg == ST_DISC |=> out_idle) // RULE_04
    else $error("output active in disconnect");
  chk_idle_entry: assert property ((!out_idle && idle_target) |-> ##[1:ENTRY_W] out_idle) // RULE_12
    else $error("idle entry too slow");
  chk_idle_exit: assert property ((out_idle && !idle_target) |-> ##[1:EXIT_W] !out_idle) // RULE_13
    else $error("idle exit too slow");
  chk_apb_ready: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
    else $error("ready not a single cycle");

  // Register bus answers.
  chk_apb_err: assert property ((psel && penable && !pready && !mapped) |=>
    pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  chk_ctrl_read: assert property ((psel && penable && !pready && !pwrite && paddr == rdm_pkg::ADDR_CTRL) |=>
    prdata == {30'h0, $past(ctrl_reg)}) else $error("control read data wrong");

  // Main scenarios the bench is expected to reach.
  cov_connect: cover property (state_reg == ST_DISC ##1 state_reg == ST_U0);
  cov_low_pwr: cover property (state_reg == ST_U0 ##1 state_reg == ST_U23);
  cov_unplug: cover property (state_reg == ST_U23 ##1 state_reg == ST_DISC);
  cov_lfps: cover property (lfps_any && state_reg == ST_U23 ##1 state_reg == ST_U0);
  cov_idle_exit: cover property (out_idle ##1 !out_idle);

endmodule

// File: verilog/rdm_pkg.sv
// Constants, types and lookup tables for the re-driver mux control block.
// Assumes a single 125 MHz clock and APB access to the control registers.
// Summary of operation
// RULE_01: Orientation high routes channel 1, else channel 2.
// RULE_02: Unselected receive pair gets weak termination only.
// RULE_03: Repeat receiver detection; on success enable termination.
// RULE_04: Exactly three power states: disconnect, U2/U3, U0.
// RULE_05: Disconnect polls both outputs; U0 on both terminated.
// RULE_06: U0 holds while traffic keeps arriving.
// RULE_07: U2/U3 keeps polling far-end termination.
// RULE_08: LFPS on input disables de-emphasis on output.
// RULE_09: Configuration pins decode low, float, high distinctly.
// RULE_10: Processor-side settings follow the nine-entry table.
// RULE_11: Connector-side settings follow the nine-entry table.
// RULE_12: Leaving U0, output goes idle after entry delay.
// RULE_13: Idle break starts output signalling within exit delay.
// RULE_14: Pin levels are two-bit codes; FH reads 3.5.
package rdm_pkg;

  // Three-state pin level codes; the fourth code is taken as float.
  localparam logic [1:0] LVL_LOW   = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH  = 2'h2;

  // De-emphasis, swing and equalization setting codes.
  localparam logic [1:0] DE_0DB  = 2'h0;
  localparam logic [1:0] DE_35DB = 2'h1;
  localparam logic [1:0] DE_6DB  = 2'h2;
  localparam logic       OS_09V  = 1'b0;
  localparam logic       OS_11V  = 1'b1;
  localparam logic [1:0] EQ_0DB  = 2'h0;
  localparam logic [1:0] EQ_3DB  = 2'h1;
  localparam logic [1:0] EQ_6DB  = 2'h2;
  localparam logic [1:0] EQ_9DB  = 2'h3;

  // Minimum weak termination of an unselected receive pair, in kilo-ohms.
  localparam int TERM_MIN_KOHM = 50;

  // One driver and receiver setting.
  typedef struct packed {
    logic [1:0] de;
    logic       os;
    logic [1:0] eq;
  } rdm_set_t;

  // Routing and termination controls for the two connector channels.
  typedef struct packed {
    logic ch1_active;
    logic ch2_active;
    logic ch1_rx_weak_term;
    logic ch2_rx_weak_term;
  } rdm_mux_t;

  // Settings indexed by level(a) * 3 + level(b).
  localparam rdm_set_t PROC_TBL [0:8] = '{
    '{DE_35DB, OS_11V, EQ_3DB}, '{DE_35DB, OS_09V, EQ_3DB}, '{DE_0DB, OS_11V, EQ_3DB},
    '{DE_0DB, OS_09V, EQ_3DB}, '{DE_35DB, OS_11V, EQ_0DB}, '{DE_35DB, OS_09V, EQ_0DB},
    '{DE_0DB, OS_11V, EQ_0DB}, '{DE_0DB, OS_09V, EQ_0DB}, '{DE_6DB, OS_11V, EQ_6DB}};
  localparam rdm_set_t CONN_TBL [0:8] = '{
    '{DE_6DB, OS_11V, EQ_0DB}, '{DE_35DB, OS_11V, EQ_0DB}, '{DE_35DB, OS_09V, EQ_0DB},
    '{DE_6DB, OS_09V, EQ_0DB}, '{DE_35DB, OS_11V, EQ_6DB}, '{DE_35DB, OS_09V, EQ_6DB},
    '{DE_6DB, OS_11V, EQ_6DB}, '{DE_6DB, OS_09V, EQ_6DB}, '{DE_6DB, OS_11V, EQ_9DB}};

  // Electrical idle delays and the cycle counts derived from the clock.
  localparam int CLK_PERIOD_NS      = 8;
  localparam int T_IDLE_ENTRY_NS    = 6;
  localparam int T_IDLE_EXIT_NS     = 6;
  localparam int IDLE_ENTRY_CYC     = (T_IDLE_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 : T_IDLE_ENTRY_NS / CLK_PERIOD_NS;
  localparam int IDLE_EXIT_CYC      = (T_IDLE_EXIT_NS / CLK_PERIOD_NS < 1) ? 1 : T_IDLE_EXIT_NS / CLK_PERIOD_NS;
  localparam logic [3:0] IDLE_ENTRY = 4'(IDLE_ENTRY_CYC);
  localparam logic [3:0] IDLE_EXIT  = 4'(IDLE_EXIT_CYC);

  // Register map, byte addresses, and reset values.
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_SETTINGS = 8'h08;
  localparam logic [1:0]  CTRL_RESET    = 2'h3;
  localparam int          CTRL_DET_EN   = 0;
  localparam int          CTRL_LFPS_AUTO = 1;
  localparam int          SET_CONN_LSB  = 8;

  // Power state codes as shown in the status register.
  localparam logic [1:0] PS_DISC = 2'h0;
  localparam logic [1:0] PS_U23  = 2'h1;
  localparam logic [1:0] PS_U0   = 2'h2;

endpackage

// File: verif/rdm_link_model.sv
// Far-end link model that answers receiver-detection requests of the block.
// Assumes requests are single-cycle pulses on rxdet_req, synchronous to pclk.
`timescale 1ns/100ps

module rdm_link_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rxdet_req,
  input  wire logic       far_present,
  input  wire logic [3:0] det_lat,
  output logic            term_det_done,
  output logic            term_det_both
);
  logic [3:0] wait_reg;  // Cycles left before the result is reported.
  logic       busy_reg;  // A detection is in progress.

  // Report each detection det_lat + 1 cycles after the request, so answers can be prompt or slow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg      <= 4'h0;
      busy_reg      <= 1'b0;
      term_det_done <= 1'b0;
    end else if (rxdet_req) begin
      wait_reg      <= det_lat;
      busy_reg      <= 1'b1;
      term_det_done <= 1'b0;
    end else begin
      term_det_done <= busy_reg && (wait_reg == 4'h0);
      busy_reg      <= busy_reg && (wait_reg != 4'h0);
      wait_reg      <= (wait_reg == 4'h0) ? 4'h0 : wait_reg - 4'h1;
    end
  end

  // The result is only meaningful with done; otherwise it shows the opposite level.
  assign term_det_both = term_det_done ? far_present : ~far_present;
endmodule

// File: verif/rdm_ctrl_tb.sv
// Self-checking bench for the re-driver mux control block.
// Assumes the link model in rdm_link_model.sv and an APB master in tasks here.
`timescale 1ns/100ps

module rdm_ctrl_tb;
  localparam int         DET = 8;  // Short poll interval keeps the run brief.
  localparam logic [1:0] lo  = rdm_pkg::LVL_LOW;
  localparam logic [1:0] fl  = rdm_pkg::LVL_FLOAT;
  localparam logic [1:0] hi  = rdm_pkg::LVL_HIGH;
  localparam logic [1:0] d0  = rdm_pkg::DE_0DB;
  localparam logic [1:0] d35 = rdm_pkg::DE_35DB;
  localparam logic [1:0] d6  = rdm_pkg::DE_6DB;
  localparam logic       o09 = rdm_pkg::OS_09V;
  localparam logic       o11 = rdm_pkg::OS_11V;
  // One table row: orientation and pin levels beside the expected settings.
  typedef struct packed {
    logic              sel;
    logic [1:0]        pa, pb, ca, cb;
    rdm_pkg::rdm_set_t pe, ce;
  } rdm_row_t;
  rdm_row_t rows [10] = '{
    '{1'b1, lo, lo, lo, lo, '{d35, o11, 2'h1}, '{d6, o11, 2'h0}},
    '{1'b0, lo, fl, lo, fl, '{d35, o09, 2'h1}, '{d35, o11, 2'h0}},
    '{1'b1, lo, hi, lo, hi, '{d0, o11, 2'h1}, '{d35, o09, 2'h0}},
    '{1'b0, fl, lo, fl, lo, '{d0, o09, 2'h1}, '{d6, o09, 2'h0}},
    '{1'b1, fl, fl, fl, fl, '{d35, o11, 2'h0}, '{d35, o11, 2'h2}},
    '{1'b0, fl, hi, fl, hi, '{d35, o09, 2'h0}, '{d35, o09, 2'h2}},
    '{1'b1, hi, lo, hi, lo, '{d0, o11, 2'h0}, '{d6, o11, 2'h2}},
    '{1'b0, hi, fl, hi, fl, '{d0, o09, 2'h0}, '{d6, o09, 2'h2}},
    '{1'b1, hi, hi, hi, hi, '{d6, o11, 2'h2}, '{d6, o11, 2'h3}},
    '{1'b0, 2'h3, 2'h3, 2'h3, lo, '{d35, o11, 2'h0}, '{d6, o09, 2'h0}}};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              sel, done, both, lfps_p, lfps_c, traffic, far_present, err;
  logic [1:0]        pa, pb, ca, cb;
  logic [3:0]        det_lat;
  rdm_pkg::rdm_mux_t mux_out;
  rdm_pkg::rdm_set_t proc_drv, conn_drv;
  logic              rxdet_req, rx_term_en, out_idle;
  int                errors, checks_done, req_cnt, n0;

  rdm_ctrl #(.DET_PERIOD(DET)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .orientation_select(sel), .proc_cfg_a(pa), .proc_cfg_b(pb), .conn_cfg_a(ca), .conn_cfg_b(cb),
    .term_det_done(done), .term_det_both(both), .lfps_det_proc(lfps_p), .lfps_det_conn(lfps_c),
    .traffic_det(traffic), .mux_out(mux_out), .proc_drv(proc_drv), .conn_drv(conn_drv),
    .rxdet_req(rxdet_req), .rx_term_en(rx_term_en), .out_idle(out_idle));
  rdm_link_model i_link (.pclk(pclk), .presetn(presetn), .rxdet_req(rxdet_req), .far_present(far_present),
    .det_lat(det_lat), .term_det_done(done), .term_det_both(both));

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;
  // Count detection request pulses as seen at each rising edge.
  always @(posedge pclk) if (rxdet_req === 1'b1) req_cnt++;

  // Compare tasks for plain words and for driver settings.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_set(input rdm_pkg::rdm_set_t got, input rdm_pkg::rdm_set_t exp, input string what);
    chk_val({27'h0, got}, {27'h0, exp}, what);
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdo,
                     output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdo = prdata;
    er = pslverr;
    if (n >= 50) chk_val(32'h0, 32'h1, "apb wait");
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Wait a bounded time for the receive termination to reach a level.
  task automatic wait_term(input logic exp);
    int n;
    n = 0;
    while (rx_term_en !== exp && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk_val({31'h0, rx_term_en}, {31'h0, exp}, "termination");
  endtask
  task automatic status_is(input logic [1:0] st);
    apb(1'b0, rdm_pkg::ADDR_STATUS, 32'h0, rd, err);
    chk_val({30'h0, rd[1:0]}, {30'h0, st}, "power state");
  endtask
  // Print the counts and the verdict, then end the run.
  task automatic finish_test;
    $display("Checks: %0d  errors: %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end

  // Main sequence: reset, table of settings, then link and register cases.
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sel, pa, pb, ca, cb, lfps_p, lfps_c, traffic, far_present} = '0;
    {errors, checks_done, req_cnt} = '0;
    det_lat = 4'h2;
    repeat (3) @(posedge pclk);
    chk_val({30'h0, out_idle, rx_term_en}, 32'h2, "reset outputs");
    presetn <= 1'b1;
    apb(1'b0, rdm_pkg::ADDR_CTRL, 32'h0, rd, err);
    chk_val(rd, 32'h3, "ctrl reset");
    status_is(rdm_pkg::PS_DISC);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      sel <= rows[i].sel; pa <= rows[i].pa; pb <= rows[i].pb; ca <= rows[i].ca; cb <= rows[i].cb;
      repeat (2) @(posedge pclk);
      chk_set(proc_drv, rows[i].pe, "proc settings");
      chk_set(conn_drv, rows[i].ce, "conn settings");
      chk_val({28'h0, mux_out}, rows[i].sel ? 32'h9 : 32'h6, "routing");
    end
    @(posedge pclk);
    far_present <= 1'b1; traffic <= 1'b1;
    wait_term(1'b1);
    status_is(rdm_pkg::PS_U0);
    n0 = req_cnt;
    repeat (4 * DET) @(posedge pclk);
    chk_val(req_cnt - n0, 32'h0, "requests in active state");
    status_is(rdm_pkg::PS_U0);
    chk_val({31'h0, out_idle}, 32'h0, "active output");
    @(posedge pclk);
    traffic <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_val({31'h0, out_idle}, 32'h1, "idle entry");
    status_is(rdm_pkg::PS_U23);
    n0 = req_cnt;
    repeat (3 * DET) @(posedge pclk);
    chk_val({31'h0, req_cnt > n0}, 32'h1, "polling in low power");
    @(posedge pclk);
    lfps_c <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_val({31'h0, out_idle}, 32'h0, "idle exit");
    chk_val({30'h0, proc_drv.de}, 32'h0, "proc de off");
    chk_val({30'h0, conn_drv.de}, {30'h0, d6}, "conn de kept");
    lfps_c <= 1'b0; lfps_p <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_val({30'h0, conn_drv.de}, 32'h0, "conn de off");
    status_is(rdm_pkg::PS_U0);
    lfps_p <= 1'b0; far_present <= 1'b0; det_lat <= 4'h0;
    wait_term(1'b0);
    status_is(rdm_pkg::PS_DISC);
    apb(1'b1, rdm_pkg::ADDR_CTRL, 32'h0, rd, err);
    apb(1'b0, rdm_pkg::ADDR_CTRL, 32'h0, rd, err);
    chk_val(rd, 32'h0, "ctrl write");
    n0 = req_cnt;
    repeat (3 * DET) @(posedge pclk);
    chk_val(req_cnt - n0, 32'h0, "polling disabled");
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk_val({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b0, rdm_pkg::ADDR_SETTINGS, 32'h0, rd, err);
    chk_val(rd, {19'h0, d6, o09, 2'h0, 3'h0, d35, o11, 2'h0}, "settings word");
    // Mid-run reset: outputs and the control register return to their reset values.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_val({26'h0, mux_out, out_idle, rx_term_en}, 32'h2, "mid-run reset outputs");
    presetn <= 1'b1;
    apb(1'b0, rdm_pkg::ADDR_CTRL, 32'h0, rd, err);
    chk_val(rd, 32'h3, "ctrl after reset");
    status_is(rdm_pkg::PS_DISC);
    finish_test;
  end
endmodule
